// [logic/gdm_pkg.sv]
// Package: constants and types of the gate driver mode controller
package gdm_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_MHZ          = 20;
  localparam int unsigned SIG_CHECK_NS     = 1200;
  localparam int unsigned SIG_CHECK_CYC    = (SIG_CHECK_NS * CLK_MHZ) / 1000;
  localparam int unsigned CLEAR_MIN_NS     = 2200;
  localparam int unsigned CLEAR_CYC        = (CLEAR_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned FAULT_EXT_US     = 10;
  localparam int unsigned FAULT_EXT_CYC    = FAULT_EXT_US * CLK_MHZ;
  localparam int unsigned CFG_TIMEOUT_MS   = 100;
  localparam int unsigned CFG_TIMEOUT_CYC  = CFG_TIMEOUT_MS * CLK_MHZ * 1000;
  localparam int unsigned PD_STEP_CYC      = 4;
  localparam int unsigned TMR_W            = 24;

  // ****************************************
  // Status bit positions
  // ****************************************
  localparam int unsigned SPI_SIG_DONE_BIT = 3;
  localparam int unsigned SEV_REDUCED_BIT  = 0;
  localparam int unsigned SEV_LIMP_BIT     = 1;
  localparam int unsigned SEV_CUTOFF_BIT   = 3;
  localparam logic [7:0]  SEV_RST          = 8'h00;
  localparam logic [7:0]  SPI_STAT_RST     = 8'h00;

  // ****************************************
  // Mode and power-down step enumerations
  // ****************************************
  typedef enum logic [3:0] {
    GDM_SLEEP, GDM_IDLE, GDM_CONFIG, GDM_CFG_LOCK, GDM_DRIVING, GDM_LIMP,
    GDM_REDUCED, GDM_SAFE_OFF, GDM_ERROR, GDM_POWER_DOWN
  } gdm_mode_t;

  typedef enum logic [2:0] {
    PD_NONE, PD_FETS_OFF, PD_RAIL_CHECK, PD_PERIPH_OFF, PD_CORE_RESET
  } gdm_pd_step_t;

endpackage

// [logic/gdm_sync.sv]
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module gdm_sync (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  // Data
  input  wire logic d_i,
  output logic      q_o
);
  logic meta;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      meta <= 1'b0;
      q_o  <= 1'b0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule // gdm_sync

// [logic/gdm_pulse_timer.sv]
// Low-pulse width detector for the drive-permit pin
`timescale 1ns/100ps
module gdm_pulse_timer
  import gdm_pkg::*;
(
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  // Synchronised pin level
  input  wire logic level_i,
  // One-cycle pulse on release after a long enough low time
  output logic      clear_o
);
  logic [7:0] cnt;
  logic       long_low;
  logic       prev;

  assign long_low = (cnt >= 8'(CLEAR_CYC));

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      cnt     <= 8'h00;
      prev    <= 1'b1;
      clear_o <= 1'b0;
    end else begin
      prev    <= level_i;
      clear_o <= level_i && !prev && long_low;
      if (level_i) begin
        if (prev) cnt <= 8'h00;
      end else if (!long_low) begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule // gdm_pulse_timer

// [logic/gdm_mode_ctrl.sv]
// Operation-mode controller of a three-phase gate driver
// Operation
// - Idle moves to configuration on first valid config register write.
// - First valid write starts the configuration timer and pulls fault low.
// - Entering normal mode clears error indications and error filters.
// - Signature compared to CRC8 within 1.2 us, then SPI status bit 3 set.
// - Reduced operation halts config timer; recovery re-enters config, timer reset.
// - Timer expiry locks configuration until inhibit reset.
// - Inhibit low starts power-down toward sleep.
// - Inhibit changes ignored after low detect until sleep reached.
// - Power-down order: FETs off, rail check, peripherals off, core reset.
// - Sleep discards configuration; full reconfiguration needed.
// - Wake to idle; fault pin high signals readiness.
// - Reduced operation keeps registers, disables SPI, digital pins, amplifier.
// - Reduced to normal clears latched errors, sets event bit 0.
// - Limp only if enabled in configuration; sets event bit 1.
// - Safe-off low turns FETs off; SPI and shunt amplifier stay on.
// - Error mode on fault low in normal operation unless reduced or safe-off applies; warnings never cause error mode.
// - Latched errors need drive-permit reset; others recover automatically.
// - Cut-off triggered by watchdog or supply fault after delay; sets bit 3.
// - Cut-off runs to end unless inhibit low; flag cleared by drive-permit reset.
// - Drive-permit low pulse clears latched errors only if long enough.
// - Fault pin low indication extended by 10 us.
`timescale 1ns/100ps
module gdm_mode_ctrl
  import gdm_pkg::*;
#(
  parameter int unsigned CFG_TIMEOUT = CFG_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             nrst_i,
  // Control pins
  input  wire logic             inhibit_n_pin_i,
  input  wire logic             drive_permit_pin_i,
  input  wire logic             safe_off_n_pin_i,
  input  wire logic             high_side_input_i,
  input  wire logic             low_side_input_i,
  // SPI configuration events from the frame decoder
  input  wire logic             cfg_write_i,
  input  wire logic             sig_valid_i,
  input  wire logic [7:0]       sig_byte_i,
  input  wire logic [7:0]       crc8_i,
  input  wire logic             limp_en_i,
  // Supervision and supply status
  input  wire logic             supply_low_i,
  input  wire logic             rail_uv_i,
  input  wire logic             err_latched_i,
  input  wire logic             err_auto_i,
  input  wire logic             warn_i,
  input  wire logic             limp_req_i,
  // Cut-off trigger configuration
  input  wire logic             wdog_fail_i,
  input  wire logic             vcc_fault_i,
  input  wire logic             cutoff_src_wdog_i,
  input  wire logic [15:0]      cutoff_delay_i,
  // Outputs
  output gdm_pkg::gdm_mode_t    mode_o,
  output gdm_pkg::gdm_pd_step_t pd_step_o,
  output logic                  fault_n_pin_o,
  output logic                  fets_on_o,
  output logic                  high_side_o,
  output logic                  low_side_o,
  output logic                  spi_en_o,
  output logic                  shunt_amplifier_en_o,
  output logic                  pins_en_o,
  output logic                  core_reset_o,
  output logic                  error_clear_o,
  output logic                  latched_err_o,
  output logic [7:0]            spi_status_o,
  output logic [7:0]            special_event_o,
  output logic                  cutoff_o
);
  import gdm_pkg::*;

  // ****************************************
  // Pin synchronisation
  // ****************************************
  logic inh_s, dp_s, safe_off_n_pin_s;

  gdm_sync u_inh  (.mclk_i(mclk_i), .nrst_i(nrst_i), .d_i(inhibit_n_pin_i),    .q_o(inh_s));
  gdm_sync u_dp   (.mclk_i(mclk_i), .nrst_i(nrst_i), .d_i(drive_permit_pin_i), .q_o(dp_s));
  gdm_sync u_safe_off_n_pin (.mclk_i(mclk_i), .nrst_i(nrst_i), .d_i(safe_off_n_pin_i),   .q_o(safe_off_n_pin_s));

  logic dp_clear;
  gdm_pulse_timer u_dpt (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .level_i(dp_s),
    .clear_o(dp_clear)
  );

  // ****************************************
  // Mode state
  // ****************************************
  gdm_mode_t    mode, next_mode;
  gdm_mode_t    resume_mode;
  logic [TMR_W-1:0] cfg_tmr;
  logic         cfg_done;
  logic         limp_armed;
  logic [4:0]   sig_cnt;
  logic         sig_busy;
  logic [7:0]   sig_hold;
  logic [4:0]   pd_cnt;
  gdm_pd_step_t pd_step;
  logic [7:0]   ext_cnt;
  logic         latched;
  logic         fault_raw;
  logic         in_normal;
  logic         enter_normal;

  assign in_normal    = (mode == GDM_DRIVING) || (mode == GDM_LIMP);
  assign enter_normal = (next_mode == GDM_DRIVING) && !in_normal && (mode != GDM_ERROR)
                        && (mode != GDM_SAFE_OFF);
  // Warnings deliberately left out of the fault condition
  assign fault_raw    = latched || err_auto_i;

  always_comb begin
    next_mode = mode;
    unique case (mode)
      GDM_SLEEP:      if (inh_s && !supply_low_i) next_mode = GDM_IDLE;
      GDM_IDLE:       if (cfg_write_i) next_mode = GDM_CONFIG;
      GDM_CONFIG: begin
        if (supply_low_i) next_mode = GDM_REDUCED;
        else if (cfg_done) next_mode = GDM_DRIVING;
        else if (cfg_tmr >= TMR_W'(CFG_TIMEOUT)) next_mode = GDM_CFG_LOCK;
      end
      GDM_CFG_LOCK:   next_mode = GDM_CFG_LOCK;
      GDM_REDUCED:    if (!supply_low_i) next_mode = resume_mode;
      GDM_DRIVING, GDM_LIMP, GDM_SAFE_OFF, GDM_ERROR: begin
        if (supply_low_i) next_mode = GDM_REDUCED;
        else if (!safe_off_n_pin_s) next_mode = GDM_SAFE_OFF;
        else if (fault_n_pin_o == 1'b0) next_mode = GDM_ERROR;
        else if (limp_req_i && limp_armed) next_mode = GDM_LIMP;
        else next_mode = GDM_DRIVING;
      end
      GDM_POWER_DOWN: if (pd_step == PD_CORE_RESET && pd_cnt == 5'h00) next_mode = GDM_SLEEP;
    endcase
    // Inhibit wins everywhere except in sleep and once power-down is running
    if (!inh_s && mode != GDM_POWER_DOWN && mode != GDM_SLEEP)
      next_mode = GDM_POWER_DOWN;
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) mode <= GDM_SLEEP;
    else         mode <= next_mode;
  end

  // Mode to return to after reduced operation
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) resume_mode <= GDM_CONFIG;
    else if (next_mode == GDM_REDUCED && mode != GDM_REDUCED)
      resume_mode <= (mode == GDM_CONFIG) ? GDM_CONFIG : GDM_DRIVING;
  end

  // ****************************************
  // Configuration timer and signature check
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (!nrst_i || mode != GDM_CONFIG) cfg_tmr <= '0;
    else if (!supply_low_i) cfg_tmr <= cfg_tmr + TMR_W'(1);
  end

  // A check runs a fixed latency so software sees a constant response time
  always_ff @(posedge mclk_i) begin
    if (!nrst_i || mode == GDM_SLEEP || mode == GDM_POWER_DOWN) begin
      sig_busy     <= 1'b0;
      sig_cnt      <= 5'h00;
      sig_hold     <= 8'h00;
      cfg_done     <= 1'b0;
      spi_status_o <= SPI_STAT_RST;
    end else if (sig_valid_i && mode == GDM_CONFIG && !sig_busy) begin
      sig_busy <= 1'b1;
      sig_cnt  <= 5'h00;
      sig_hold <= sig_byte_i;
    end else if (sig_busy) begin
      sig_cnt <= sig_cnt + 5'h01;
      if (sig_cnt == 5'(SIG_CHECK_CYC - 2)) begin
        sig_busy <= 1'b0;
        cfg_done <= (sig_hold == crc8_i);
        spi_status_o[SPI_SIG_DONE_BIT] <= 1'b1;
      end
    end else if (mode != GDM_CONFIG) begin
      cfg_done <= 1'b0;
    end
  end

  // Limp permission captured only while configuring
  always_ff @(posedge mclk_i) begin
    if (!nrst_i || mode == GDM_SLEEP) limp_armed <= 1'b0;
    else if (mode == GDM_CONFIG) limp_armed <= limp_en_i;
  end

  // ****************************************
  // Power-down sequence
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (!nrst_i || mode != GDM_POWER_DOWN) begin
      pd_step <= PD_NONE;
      pd_cnt  <= 5'h00;
    end else if (pd_step == PD_NONE) begin
      pd_step <= PD_FETS_OFF;
      pd_cnt  <= 5'(PD_STEP_CYC);
    end else if (pd_cnt != 5'h00) begin
      pd_cnt <= pd_cnt - 5'h01;
    end else begin
      unique case (pd_step)
        PD_FETS_OFF:   pd_step <= PD_RAIL_CHECK;
        PD_RAIL_CHECK: if (rail_uv_i) pd_step <= PD_PERIPH_OFF;
        PD_PERIPH_OFF: pd_step <= PD_CORE_RESET;
        default:       pd_step <= pd_step;
      endcase
      if (pd_step != PD_RAIL_CHECK || rail_uv_i) pd_cnt <= 5'(PD_STEP_CYC);
    end
  end

  assign pd_step_o    = pd_step;
  assign core_reset_o = (pd_step == PD_CORE_RESET) || (mode == GDM_SLEEP);

  // ****************************************
  // Errors and fault pin
  // ****************************************
  assign error_clear_o = enter_normal
                         || (mode == GDM_REDUCED && next_mode == GDM_DRIVING);

  always_ff @(posedge mclk_i) begin
    if (!nrst_i || mode == GDM_SLEEP) latched <= 1'b0;
    else if (err_latched_i) latched <= 1'b1;
    else if (dp_clear || error_clear_o) latched <= 1'b0;
  end
  assign latched_err_o = latched;

  // Extension counter holds the pin low after the cause goes away
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) ext_cnt <= 8'h00;
    else if (fault_raw) ext_cnt <= 8'(FAULT_EXT_CYC);
    else if (error_clear_o) ext_cnt <= 8'h00;
    else if (ext_cnt != 8'h00) ext_cnt <= ext_cnt - 8'h01;
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) fault_n_pin_o <= 1'b0;
    else unique case (next_mode)
      GDM_IDLE:                  fault_n_pin_o <= 1'b1;
      GDM_CONFIG, GDM_CFG_LOCK:  fault_n_pin_o <= 1'b0;
      GDM_DRIVING, GDM_LIMP, GDM_SAFE_OFF, GDM_ERROR:
        fault_n_pin_o <= !(fault_raw || ext_cnt != 8'h00) || error_clear_o;
      default:                   fault_n_pin_o <= 1'b0;
    endcase
  end

  // ****************************************
  // Special events and phase cut-off
  // ****************************************
  logic        cut_trig, cut_pend;
  logic [15:0] cut_cnt;

  assign cut_trig = cutoff_src_wdog_i ? wdog_fail_i : vcc_fault_i;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i || mode == GDM_POWER_DOWN || mode == GDM_SLEEP) begin
      cut_pend <= 1'b0;
      cut_cnt  <= 16'h0000;
      cutoff_o <= 1'b0;
    end else if (cut_pend) begin
      if (cut_cnt == 16'h0000) cutoff_o <= 1'b1;
      else cut_cnt <= cut_cnt - 16'h0001;
    end else if (cut_trig && in_normal) begin
      cut_pend <= 1'b1;
      cut_cnt  <= cutoff_delay_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i || mode == GDM_SLEEP) special_event_o <= SEV_RST;
    else begin
      if (mode == GDM_REDUCED && next_mode != GDM_REDUCED)
        special_event_o[SEV_REDUCED_BIT] <= 1'b1;
      special_event_o[SEV_LIMP_BIT] <= (next_mode == GDM_LIMP);
      if (cut_trig && in_normal)
        special_event_o[SEV_CUTOFF_BIT] <= 1'b1;
      else if (dp_clear)
        special_event_o[SEV_CUTOFF_BIT] <= 1'b0;
    end
  end

  // ****************************************
  // Drive and enables
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      fets_on_o   <= 1'b0;
      high_side_o <= 1'b0;
      low_side_o  <= 1'b0;
    end else begin
      fets_on_o   <= in_normal && safe_off_n_pin_s && dp_s && inh_s;
      high_side_o <= in_normal && safe_off_n_pin_s && dp_s && inh_s && high_side_input_i;
      low_side_o  <= in_normal && safe_off_n_pin_s && dp_s && inh_s && low_side_input_i;
    end
  end

  assign mode_o               = mode;
  assign spi_en_o             = !(mode inside {GDM_REDUCED, GDM_SLEEP, GDM_POWER_DOWN});
  assign pins_en_o            = spi_en_o;
  assign shunt_amplifier_en_o = spi_en_o;
endmodule // gdm_mode_ctrl

// [testbench/gdm_mcu_model.sv]
// Behavioural host controller: configuration events and drive-permit pulses
`timescale 1ns/100ps
module gdm_mcu_model (
  // Clock
  input  wire logic       mclk_i,
  // Requests from the bench
  input  wire logic       cfg_go_i,
  input  wire logic       sig_go_i,
  input  wire logic       clr_go_i,
  input  wire logic [7:0] sig_i,
  input  wire logic [7:0] len_i,
  // Toward the driver
  output logic            cfg_write_o,
  output logic            sig_valid_o,
  output logic [7:0]      sig_byte_o,
  output logic            drive_permit_o
);
  logic [7:0] sig_cnt;
  logic [7:0] clr_cnt;
  initial begin
    {cfg_write_o, sig_valid_o, sig_cnt, clr_cnt, sig_byte_o} = '0;
    drive_permit_o = 1'h1;
  end
  // Signature leaves len_i + 1 cycles after the request, so a slow host can be mimicked
  always @(posedge mclk_i) begin
    cfg_write_o <= cfg_go_i;
    sig_valid_o <= (sig_cnt == 8'h01);
    sig_cnt <= sig_go_i ? len_i + 8'h01 : ((sig_cnt != 8'h00) ? sig_cnt - 8'h01 : 8'h00);
    // Byte lane is released outside the strobe: it toggles instead of holding the last byte
    sig_byte_o <= (sig_cnt == 8'h01) ? sig_i : ~sig_byte_o;
  end
  // Drive permit low for about len_i cycles, then high again
  always @(posedge mclk_i) begin
    clr_cnt <= clr_go_i ? len_i : ((clr_cnt != 8'h00) ? clr_cnt - 8'h01 : 8'h00);
    drive_permit_o <= (!clr_go_i && (clr_cnt <= 8'h01));
  end
endmodule // gdm_mcu_model

// [testbench/gdm_mode_ctrl_properties.sv]
// Concurrent checks on the mode controller ports
`timescale 1ns/100ps
module gdm_mode_ctrl_chk
  import gdm_pkg::*;
#(
  parameter int unsigned CFG_TIMEOUT = 200
) (
  // Clock and reset
  input wire logic                  mclk_i,
  input wire logic                  nrst_i,
  // Inputs
  input wire logic                  inhibit_n_pin_i,
  input wire logic                  safe_off_n_pin_i,
  input wire logic                  cfg_write_i,
  input wire logic                  sig_valid_i,
  input wire logic                  supply_low_i,
  input wire logic                  err_auto_i,
  input wire logic                  wdog_fail_i,
  input wire logic                  cutoff_src_wdog_i,
  // Outputs
  input wire gdm_pkg::gdm_mode_t    mode_o,
  input wire gdm_pkg::gdm_pd_step_t pd_step_o,
  input wire logic                  fault_n_pin_o,
  input wire logic                  fets_on_o,
  input wire logic                  spi_en_o,
  input wire logic                  shunt_amplifier_en_o,
  input wire logic                  error_clear_o,
  input wire logic [7:0]            spi_status_o,
  input wire logic [7:0]            special_event_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // ****************************************
  // Properties
  // ****************************************
  property p_cfg_enter;
    (inhibit_n_pin_i [*3]) ##0 (mode_o == GDM_IDLE && cfg_write_i && !supply_low_i)
      |=> mode_o == GDM_CONFIG && !fault_n_pin_o;
  endproperty
  a_cfg_enter: assert property (p_cfg_enter) else $error("config entry wrong");
  property p_sig_done;
    mode_o == GDM_CONFIG && sig_valid_i && !spi_status_o[SPI_SIG_DONE_BIT] && !supply_low_i
      |-> ##[1:24] spi_status_o[SPI_SIG_DONE_BIT];
  endproperty
  a_sig_done: assert property (p_sig_done) else $error("signature check late");
  property p_norm_entry;
    mode_o == GDM_DRIVING && $past(mode_o) == GDM_CONFIG |-> $past(error_clear_o) && fault_n_pin_o;
  endproperty
  a_norm_entry: assert property (p_norm_entry) else $error("normal entry no clear");
  property p_lock;
    mode_o == GDM_CFG_LOCK |=> mode_o inside {GDM_CFG_LOCK, GDM_POWER_DOWN, GDM_REDUCED};
  endproperty
  a_lock: assert property (p_lock) else $error("lock left wrongly");
  property p_pd_hold;
    mode_o == GDM_POWER_DOWN |=> mode_o inside {GDM_POWER_DOWN, GDM_SLEEP};
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("power-down abandoned");
  property p_pd_order;
    pd_step_o != PD_NONE && $changed(pd_step_o) |-> pd_step_o == $past(pd_step_o) + 3'h1;
  endproperty
  a_pd_order: assert property (p_pd_order) else $error("power-down step order");
  property p_reduced;
    mode_o == GDM_REDUCED |-> !spi_en_o && !shunt_amplifier_en_o;
  endproperty
  a_reduced: assert property (p_reduced) else $error("reduced mode io active");
  property p_safe_off;
    (!safe_off_n_pin_i && inhibit_n_pin_i) [*6] |-> !fets_on_o
      && (mode_o != GDM_SAFE_OFF || (spi_en_o && shunt_amplifier_en_o));
  endproperty
  a_safe_off: assert property (p_safe_off) else $error("safe-off not honoured");
  property p_cutoff;
    mode_o == GDM_DRIVING && cutoff_src_wdog_i && wdog_fail_i |=> special_event_o[SEV_CUTOFF_BIT];
  endproperty
  a_cutoff: assert property (p_cutoff) else $error("cut-off event bit missing");
  property p_fault_ext;
    $fell(err_auto_i) && mode_o == GDM_ERROR |-> ##190 !fault_n_pin_o;
  endproperty
  a_fault_ext: assert property (p_fault_ext) else $error("fault extension short");
  c_driving: cover property (mode_o == GDM_DRIVING);
  c_lock: cover property (mode_o == GDM_CFG_LOCK);
  c_core_reset: cover property (pd_step_o == PD_CORE_RESET);
endmodule // gdm_mode_ctrl_chk
bind gdm_mode_ctrl gdm_mode_ctrl_chk #(.CFG_TIMEOUT(CFG_TIMEOUT)) gdm_mode_ctrl_chk_inst (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .inhibit_n_pin_i(inhibit_n_pin_i),
  .safe_off_n_pin_i(safe_off_n_pin_i), .cfg_write_i(cfg_write_i), .sig_valid_i(sig_valid_i),
  .supply_low_i(supply_low_i), .err_auto_i(err_auto_i), .wdog_fail_i(wdog_fail_i),
  .cutoff_src_wdog_i(cutoff_src_wdog_i), .mode_o(mode_o), .pd_step_o(pd_step_o),
  .fault_n_pin_o(fault_n_pin_o), .fets_on_o(fets_on_o), .spi_en_o(spi_en_o),
  .shunt_amplifier_en_o(shunt_amplifier_en_o), .error_clear_o(error_clear_o),
  .spi_status_o(spi_status_o), .special_event_o(special_event_o));

// [testbench/gdm_mode_ctrl_tb.sv]
// Self-checking bench of the mode controller
`timescale 1ns/100ps
module gdm_mode_ctrl_tb;
  import gdm_pkg::*;
  logic         mclk_i, nrst_i, inhibit_n_pin_i, safe_off_n_pin_i, high_side_input_i;
  logic         low_side_input_i, limp_en_i, supply_low_i, rail_uv_i, err_latched_i;
  logic         err_auto_i, warn_i, limp_req_i, wdog_fail_i, vcc_fault_i, cutoff_src_wdog_i;
  logic         cfg_write_i, sig_valid_i, drive_permit_pin_i, cfg_go, sig_go, clr_go;
  logic [7:0]   crc8_i, sig_byte_i, sig_val, len_val, spi_status_o, special_event_o;
  logic [15:0]  cutoff_delay_i;
  gdm_mode_t    mode_o;
  gdm_pd_step_t pd_step_o;
  logic         fault_n_pin_o, fets_on_o, high_side_o, low_side_o, spi_en_o, pins_en_o;
  logic         shunt_amplifier_en_o, core_reset_o, error_clear_o, latched_err_o, cutoff_o;
  int           num_errors, comparisons, s;
  gdm_mode_ctrl #(.CFG_TIMEOUT(200)) gdm_mode_ctrl_inst (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .inhibit_n_pin_i(inhibit_n_pin_i),
    .drive_permit_pin_i(drive_permit_pin_i), .safe_off_n_pin_i(safe_off_n_pin_i),
    .high_side_input_i(high_side_input_i), .low_side_input_i(low_side_input_i),
    .cfg_write_i(cfg_write_i), .sig_valid_i(sig_valid_i), .sig_byte_i(sig_byte_i),
    .crc8_i(crc8_i), .limp_en_i(limp_en_i), .supply_low_i(supply_low_i), .rail_uv_i(rail_uv_i),
    .err_latched_i(err_latched_i), .err_auto_i(err_auto_i), .warn_i(warn_i),
    .limp_req_i(limp_req_i), .wdog_fail_i(wdog_fail_i), .vcc_fault_i(vcc_fault_i),
    .cutoff_src_wdog_i(cutoff_src_wdog_i), .cutoff_delay_i(cutoff_delay_i), .mode_o(mode_o),
    .pd_step_o(pd_step_o), .fault_n_pin_o(fault_n_pin_o), .fets_on_o(fets_on_o),
    .high_side_o(high_side_o), .low_side_o(low_side_o), .spi_en_o(spi_en_o),
    .shunt_amplifier_en_o(shunt_amplifier_en_o), .pins_en_o(pins_en_o),
    .core_reset_o(core_reset_o), .error_clear_o(error_clear_o),
    .latched_err_o(latched_err_o), .spi_status_o(spi_status_o),
    .special_event_o(special_event_o), .cutoff_o(cutoff_o));
  gdm_mcu_model gdm_mcu_model_inst (
    .mclk_i(mclk_i), .cfg_go_i(cfg_go), .sig_go_i(sig_go), .clr_go_i(clr_go), .sig_i(sig_val),
    .len_i(len_val), .cfg_write_o(cfg_write_i), .sig_valid_o(sig_valid_i),
    .sig_byte_o(sig_byte_i), .drive_permit_o(drive_permit_pin_i));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic smp(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // Bounded wait, so a missing transition is reported rather than hanging
  task automatic wait_mode(input gdm_mode_t m);
    for (int i = 0; i < 400 && mode_o !== m; i++) @(negedge mclk_i);
    chk(8'(mode_o), 8'(m));
  endtask
  task automatic mcu(input logic c, s, k, input logic [7:0] len, sig);
    @(posedge mclk_i) {cfg_go, sig_go, clr_go, len_val, sig_val} <= {c, s, k, len, sig};
    @(posedge mclk_i) {cfg_go, sig_go, clr_go} <= 3'h0;
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_config;
    wait_mode(GDM_IDLE);
    smp(3);
    chk(fault_n_pin_o, 8'h01);
    @(posedge mclk_i) limp_en_i <= 1'h1;
    mcu(1'h1, 1'h0, 1'h0, 8'h03, 8'h5a);
    wait_mode(GDM_CONFIG);
    chk(fault_n_pin_o, 8'h00);
    mcu(1'h0, 1'h1, 1'h0, 8'h03, 8'h5a);
    for (int i = 0; i < 60 && error_clear_o !== 1'b1; i++) @(negedge mclk_i);
    chk(error_clear_o, 8'h01);
    smp(1);
    chk(8'(mode_o), 8'(GDM_DRIVING));
    chk(spi_status_o[SPI_SIG_DONE_BIT], 8'h01);
    @(posedge mclk_i) limp_req_i <= 1'h1;
    wait_mode(GDM_LIMP);
    smp(2);
    chk(special_event_o[SEV_LIMP_BIT], 8'h01);
    @(posedge mclk_i) limp_req_i <= 1'h0;
    wait_mode(GDM_DRIVING);
  endtask
  task automatic t_safe_off;
    @(posedge mclk_i) high_side_input_i <= 1'h1;
    smp(6);
    chk({fets_on_o, high_side_o}, 8'h03);
    @(posedge mclk_i) safe_off_n_pin_i <= 1'h0;
    wait_mode(GDM_SAFE_OFF);
    smp(2);
    chk({fets_on_o, high_side_o, spi_en_o, shunt_amplifier_en_o}, 8'h03);
    @(posedge mclk_i) {safe_off_n_pin_i, high_side_input_i} <= 2'h2;
    wait_mode(GDM_DRIVING);
  endtask
  task automatic t_reduced;
    @(posedge mclk_i) supply_low_i <= 1'h1;
    wait_mode(GDM_REDUCED);
    chk({spi_en_o, pins_en_o, shunt_amplifier_en_o}, 8'h00);
    @(posedge mclk_i) supply_low_i <= 1'h0;
    wait_mode(GDM_DRIVING);
    smp(1);
    chk(special_event_o[SEV_REDUCED_BIT], 8'h01);
    mcu(1'h0, 1'h0, 1'h1, 8'h3c, 8'h00);
    wait_mode(GDM_DRIVING);
  endtask
  task automatic t_error;
    @(posedge mclk_i) warn_i <= 1'h1;
    smp(6);
    chk(8'(mode_o), 8'(GDM_DRIVING));
    @(posedge mclk_i) {warn_i, err_latched_i} <= 2'h1;
    @(posedge mclk_i) err_latched_i <= 1'h0;
    wait_mode(GDM_ERROR);
    chk({latched_err_o, fault_n_pin_o}, 8'h02);
    mcu(1'h0, 1'h0, 1'h1, 8'h14, 8'h00);
    smp(60);
    chk(latched_err_o, 8'h01);
    mcu(1'h0, 1'h0, 1'h1, 8'h3c, 8'h00);
    smp(80);
    chk(latched_err_o, 8'h00);
    wait_mode(GDM_DRIVING);
    @(posedge mclk_i) err_auto_i <= 1'h1;
    wait_mode(GDM_ERROR);
    @(posedge mclk_i) err_auto_i <= 1'h0;
    smp(150);
    chk(fault_n_pin_o, 8'h00);
    wait_mode(GDM_DRIVING);
  endtask
  task automatic t_cutoff;
    @(posedge mclk_i) {cutoff_src_wdog_i, wdog_fail_i, cutoff_delay_i} <= {2'h3, 16'h0010};
    @(posedge mclk_i) wdog_fail_i <= 1'h0;
    smp(1);
    chk(special_event_o[SEV_CUTOFF_BIT], 8'h01);
    smp(20);
    chk(cutoff_o, 8'h01);
    mcu(1'h0, 1'h0, 1'h1, 8'h3c, 8'h00);
    smp(80);
    chk({cutoff_o, special_event_o[SEV_CUTOFF_BIT]}, 8'h02);
  endtask
  task automatic t_sleep;
    @(posedge mclk_i) {inhibit_n_pin_i, rail_uv_i} <= 2'h0;
    wait_mode(GDM_POWER_DOWN);
    @(posedge mclk_i) inhibit_n_pin_i <= 1'h1;
    for (s = 1; s <= 4; s++) begin
      for (int i = 0; i < 40 && pd_step_o !== gdm_pd_step_t'(s); i++) @(negedge mclk_i);
      chk({1'h0, pd_step_o, mode_o}, 8'(s * 16 + 9));
      if (s == 2) begin
        smp(20);
        chk(8'(pd_step_o), 8'h02);
        @(posedge mclk_i) rail_uv_i <= 1'h1;
      end
    end
    wait_mode(GDM_SLEEP);
    chk({core_reset_o, cutoff_o}, 8'h02);
    wait_mode(GDM_IDLE);
    chk(spi_status_o | special_event_o, 8'h00);
  endtask
  task automatic t_lock;
    mcu(1'h1, 1'h0, 1'h0, 8'h00, 8'h00);
    wait_mode(GDM_CONFIG);
    mcu(1'h0, 1'h1, 1'h0, 8'h00, 8'ha5);
    smp(150);
    @(posedge mclk_i) supply_low_i <= 1'h1;
    wait_mode(GDM_REDUCED);
    @(posedge mclk_i) supply_low_i <= 1'h0;
    wait_mode(GDM_CONFIG);
    smp(150);
    chk(8'(mode_o), 8'(GDM_CONFIG));
    wait_mode(GDM_CFG_LOCK);
    smp(30);
    chk(8'(mode_o), 8'(GDM_CFG_LOCK));
    @(posedge mclk_i) inhibit_n_pin_i <= 1'h0;
    wait_mode(GDM_POWER_DOWN);
    @(posedge mclk_i) inhibit_n_pin_i <= 1'h1;
    wait_mode(GDM_IDLE);
  endtask
  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial begin
    mclk_i = 1'h0;
    forever #25 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    test_done;
  end
  initial begin
    {nrst_i, high_side_input_i, low_side_input_i, limp_en_i, supply_low_i, warn_i} = '0;
    {err_latched_i, err_auto_i, limp_req_i, wdog_fail_i, vcc_fault_i, cutoff_src_wdog_i} = '0;
    {cfg_go, sig_go, clr_go, sig_val, len_val, cutoff_delay_i} = '0;
    {inhibit_n_pin_i, safe_off_n_pin_i, rail_uv_i, crc8_i} = {3'h6, 8'h5a};
    repeat (10) @(posedge mclk_i);
    nrst_i <= 1'h1;
    t_config;
    t_safe_off;
    t_reduced;
    t_error;
    t_cutoff;
    t_sleep;
    t_lock;
    test_done;
  end
endmodule // gdm_mode_ctrl_tb
